//--- rtl/pin_mux_pkg.sv
// Constants shared by the serial pin multiplexer and its register file
package pin_mux_pkg;
	localparam int NUM_CH = 3;
	localparam int PINS_PER_CH = 4;
	// Pin function index inside a channel group
	localparam int FN_TX = 0;
	localparam int FN_RX = 1;
	localparam int FN_CK = 2;
	localparam int FN_FL = 3;
	localparam int PORT_W = NUM_CH * PINS_PER_CH;
	localparam int PIN_IN_W = 3 * NUM_CH + PINS_PER_CH;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] MODE_OFS [NUM_CH] = '{8'h00, 8'h04, 8'h08};
	localparam logic [7:0] CTRL_OFS [NUM_CH] = '{8'h10, 8'h14, 8'h18};
	localparam logic [7:0] SHARED_OFS = 8'h20;
	localparam logic [7:0] PIN_ASSIGN_OFS = 8'h24;
	localparam logic [7:0] PORT6_DIR_OFS = 8'h28;
	localparam logic [7:0] PORT7_DIR_OFS = 8'h2c;
	localparam logic [7:0] PORT_DATA_OFS = 8'h30;
	localparam logic [7:0] PIN_STATUS_OFS = 8'h34;
	// Field widths and positions
	localparam int MODE_W = 3;
	localparam int MODE_EN_BIT = 0;
	localparam int MODE_CLOCK_DIRECTION_BIT_BIT = 1;
	localparam int MODE_OD_BIT = 2;
	localparam int CTRL_W = 3;
	localparam int CTRL_FSEL_BIT = 0;
	localparam int CTRL_FDIS_BIT = 1;
	localparam int CTRL_POL_BIT = 2;
	localparam int SHARED_W = 3;
	localparam int SH_SEP_BIT = 0;
	localparam int SH_MD0_BIT = 1;
	localparam int SH_MD1_BIT = 2;
	localparam int RELOC_BIT = 0;
	localparam int PORT6_W = 8;
	localparam int PORT7_W = 4;
	// Reset values
	localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h2;
	localparam logic [SHARED_W-1:0] SHARED_RST = 3'h0;
	localparam logic [PORT_W-1:0] PORT_RST = 12'h000;
endpackage

//--- rtl/pin_sync.sv
// Two-flop synchroniser bank for levels entering a clock domain
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk, // Destination clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic [W-1:0] d, // Level from another domain or a pin
	output logic [W-1:0] q // Synchronised level
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule

//--- rtl/uart_pin_flow_control_mux.sv
// Pin function multiplexer for three serial channels with flow control
`timescale 1ns/10ps
module uart_pin_flow_control_mux
	import pin_mux_pkg::*;
(
	input wire logic core_clk, // Register clock, 200 MHz
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic link_clk, // Pin-side clock
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [NUM_CH-1:0] uart_txd, // Serial engine data out
	input wire logic [NUM_CH-1:0] uart_xfer_start, // Serial engine transfer start
	input wire logic [NUM_CH-1:0] uart_clk_out, // Serial engine transfer clock
	input wire logic [NUM_CH-1:0] uart_rts_n, // Serial engine request to send
	output logic [NUM_CH-1:0] uart_rxd, // Data in to serial engine
	output logic [NUM_CH-1:0] uart_clk_in, // External clock to serial engine
	output logic [NUM_CH-1:0] uart_cts_n, // Clear to send to serial engine
	output logic [NUM_CH-1:0] serial_data_out_o, // Data output pin level
	output logic [NUM_CH-1:0] serial_data_out_oe, // Data output pin enable
	input wire logic [NUM_CH-1:0] serial_data_in_i, // Data input pin
	output logic [NUM_CH-1:0] serial_data_in_o, // Data input pin as port
	output logic [NUM_CH-1:0] serial_data_in_oe, // Data input pin port enable
	input wire logic [NUM_CH-1:0] transfer_clock_pin_i, // Clock pin input
	output logic [NUM_CH-1:0] transfer_clock_pin_o, // Clock pin level
	output logic [NUM_CH-1:0] transfer_clock_pin_oe, // Clock pin enable
	input wire logic [NUM_CH-1:0] flow_control_pin_i, // Flow pins; 0 is RTS0, 1 shared
	output logic [NUM_CH-1:0] flow_control_pin_o, // Flow pin level
	output logic [NUM_CH-1:0] flow_control_pin_oe, // Flow pin enable
	input wire logic [PINS_PER_CH-1:0] relocated_pin_i, // Alternate channel 1 group
	output logic [PINS_PER_CH-1:0] relocated_pin_o, // Alternate group level
	output logic [PINS_PER_CH-1:0] relocated_pin_oe // Alternate group enable
);
	localparam int CFG_W = NUM_CH * (MODE_W + CTRL_W) + SHARED_W + 1 + PORT_W * 2;

	logic [NUM_CH-1:0][MODE_W-1:0] channel_mode_reg, channel_mode_next;
	logic [NUM_CH-1:0][CTRL_W-1:0] channel_control0_reg, channel_control0_next;
	logic [SHARED_W-1:0] shared_serial_control_reg, shared_serial_control_next;
	logic pin_assignment_reg, pin_assignment_next;
	logic [PORT6_W-1:0] port6_direction_reg, port6_direction_next;
	logic [PORT7_W-1:0] port7_direction_reg, port7_direction_next;
	logic [PORT_W-1:0] port_data_reg, port_data_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pslverr_reg, pslverr_next;
	logic [PIN_IN_W-1:0] pin_status;
	logic [31:0] rd_word;
	logic hit;

	// Register file on the APB side
	always_comb begin
		channel_mode_next = channel_mode_reg;
		channel_control0_next = channel_control0_reg;
		shared_serial_control_next = shared_serial_control_reg;
		pin_assignment_next = pin_assignment_reg;
		port6_direction_next = port6_direction_reg;
		port7_direction_next = port7_direction_reg;
		port_data_next = port_data_reg;
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		rd_word = 32'h0;
		hit = 1'b1;
		case (paddr)
			SHARED_OFS: rd_word = 32'(shared_serial_control_reg);
			PIN_ASSIGN_OFS: rd_word = 32'(pin_assignment_reg);
			PORT6_DIR_OFS: rd_word = 32'(port6_direction_reg);
			PORT7_DIR_OFS: rd_word = 32'(port7_direction_reg);
			PORT_DATA_OFS: rd_word = 32'(port_data_reg);
			PIN_STATUS_OFS: rd_word = 32'(pin_status);
			default: hit = 1'b0;
		endcase
		for (int c = 0; c < NUM_CH; c++) begin
			if (paddr == MODE_OFS[c]) begin
				rd_word = 32'(channel_mode_reg[c]);
				hit = 1'b1;
			end
			if (paddr == CTRL_OFS[c]) begin
				rd_word = 32'(channel_control0_reg[c]);
				hit = 1'b1;
			end
		end
		if (psel && !penable) begin
			prdata_next = pwrite ? 32'h0 : rd_word;
			pslverr_next = !hit;
		end
		if (psel && penable && pwrite && hit) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (paddr == MODE_OFS[c])
					channel_mode_next[c] = pwdata[MODE_W-1:0];
				if (paddr == CTRL_OFS[c])
					channel_control0_next[c] = pwdata[CTRL_W-1:0];
			end
			case (paddr)
				SHARED_OFS: shared_serial_control_next = pwdata[SHARED_W-1:0];
				PIN_ASSIGN_OFS: pin_assignment_next = pwdata[RELOC_BIT];
				PORT6_DIR_OFS: port6_direction_next = pwdata[PORT6_W-1:0];
				PORT7_DIR_OFS: port7_direction_next = pwdata[PORT7_W-1:0];
				PORT_DATA_OFS: port_data_next = pwdata[PORT_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			channel_mode_reg <= {NUM_CH{MODE_RST}};
			channel_control0_reg <= {NUM_CH{CTRL_RST}};
			shared_serial_control_reg <= SHARED_RST;
			pin_assignment_reg <= 1'b0;
			port6_direction_reg <= '0;
			port7_direction_reg <= '0;
			port_data_reg <= PORT_RST;
			prdata_reg <= 32'h0;
			pslverr_reg <= 1'b0;
		end else begin
			channel_mode_reg <= channel_mode_next;
			channel_control0_reg <= channel_control0_next;
			shared_serial_control_reg <= shared_serial_control_next;
			pin_assignment_reg <= pin_assignment_next;
			port6_direction_reg <= port6_direction_next;
			port7_direction_reg <= port7_direction_next;
			port_data_reg <= port_data_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign pready = 1'b1;

	// Quasi-static configuration carried into the pin domain
	logic [CFG_W-1:0] cfg_l;
	logic [NUM_CH-1:0][MODE_W-1:0] mode_l;
	logic [NUM_CH-1:0][CTRL_W-1:0] ctrl_l;
	logic [SHARED_W-1:0] shared_l;
	logic reloc_l;
	logic [PORT_W-1:0] dir_l, out_l;
	logic [PIN_IN_W-1:0] pins_s;

	pin_sync #(.W(CFG_W)) u_cfg_sync (
		.clk(link_clk),
		.reset_n(reset_n),
		.d({port_data_reg, port7_direction_reg, port6_direction_reg, pin_assignment_reg,
			shared_serial_control_reg, channel_control0_reg, channel_mode_reg}),
		.q(cfg_l)
	);
	assign {out_l, dir_l, reloc_l, shared_l, ctrl_l, mode_l} = cfg_l;

	pin_sync #(.W(PIN_IN_W)) u_pin_sync (
		.clk(link_clk),
		.reset_n(reset_n),
		.d({relocated_pin_i, flow_control_pin_i, transfer_clock_pin_i, serial_data_in_i}),
		.q(pins_s)
	);

	pin_sync #(.W(PIN_IN_W)) u_status_sync (
		.clk(core_clk),
		.reset_n(reset_n),
		.d(pins_s),
		.q(pin_status)
	);

	logic [NUM_CH-1:0] rx_s, ck_s, fl_s, rx_src, ck_src, fl_src;
	logic [PINS_PER_CH-1:0] alt_s;
	logic [NUM_CH-1:0] en_l, clock_direction_bit_l, od_l, fsel_l, fdis_l, pol_l;
	logic sep_l, md0_l, md1_l;
	assign {alt_s, fl_s, ck_s, rx_s} = pins_s;
	assign sep_l = shared_l[SH_SEP_BIT];
	assign md0_l = shared_l[SH_MD0_BIT];
	assign md1_l = shared_l[SH_MD1_BIT];

	logic [NUM_CH-1:0] started_reg, started_next;
	logic [NUM_CH-1:0] tx_o_f, tx_oe_f, ck_o_f, ck_oe_f, ck_in_f, fl_o_f, fl_oe_f, cts_f;

	// Per-channel pin functions before shared-pin and relocation steering
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		localparam int B = c * PINS_PER_CH;
		logic rts_mode, cts_mode;
		assign en_l[c] = mode_l[c][MODE_EN_BIT];
		assign clock_direction_bit_l[c] = mode_l[c][MODE_CLOCK_DIRECTION_BIT_BIT];
		assign od_l[c] = mode_l[c][MODE_OD_BIT];
		assign fsel_l[c] = ctrl_l[c][CTRL_FSEL_BIT];
		assign fdis_l[c] = ctrl_l[c][CTRL_FDIS_BIT];
		assign pol_l[c] = ctrl_l[c][CTRL_POL_BIT];
		if (c == 1) begin : g_src_reloc
			assign rx_src[c] = reloc_l ? alt_s[FN_RX] : rx_s[c];
			assign ck_src[c] = reloc_l ? alt_s[FN_CK] : ck_s[c];
			assign fl_src[c] = reloc_l ? alt_s[FN_FL] : fl_s[c];
		end else begin : g_src_fixed
			assign rx_src[c] = rx_s[c];
			assign ck_src[c] = ck_s[c];
			assign fl_src[c] = fl_s[c];
		end
		// Idle until the engine starts its first transfer in this mode
		assign started_next[c] = en_l[c] & (started_reg[c] | uart_xfer_start[c]);
		// Filler from a receive-only engine is driven as any other data
		assign tx_o_f[c] = !en_l[c] ? out_l[B+FN_TX] :
			(od_l[c] ? 1'b0 : (started_reg[c] ? uart_txd[c] : 1'b1));
		assign tx_oe_f[c] = !en_l[c] ? dir_l[B+FN_TX] :
			(od_l[c] ? (started_reg[c] & ~uart_txd[c]) : 1'b1);
		assign ck_o_f[c] = (en_l[c] && !clock_direction_bit_l[c]) ? uart_clk_out[c] : out_l[B+FN_CK];
		assign ck_oe_f[c] = (en_l[c] & ~clock_direction_bit_l[c]) | dir_l[B+FN_CK];
		assign ck_in_f[c] = en_l[c] & clock_direction_bit_l[c] & ~dir_l[B+FN_CK] & ck_src[c];
		assign rts_mode = en_l[c] & ~fdis_l[c] & fsel_l[c];
		assign cts_mode = en_l[c] & ~fdis_l[c] & ~fsel_l[c] & ~dir_l[B+FN_FL];
		assign fl_o_f[c] = rts_mode ? uart_rts_n[c] : out_l[B+FN_FL];
		assign fl_oe_f[c] = rts_mode | dir_l[B+FN_FL];
		// Active-low clear; a disabled flow control clears, except channel 0 with a separated shared pin
		assign cts_f[c] = cts_mode ? fl_src[c] : ~fdis_l[c];
	end

	logic [NUM_CH-1:0] tx_o_next, tx_oe_next, rx_o_next, rx_oe_next;
	logic [NUM_CH-1:0] ck_o_next, ck_oe_next, fl_o_next, fl_oe_next;
	logic [NUM_CH-1:0] rxd_next, clk_in_next, cts_next;
	logic [PINS_PER_CH-1:0] alt_o_next, alt_oe_next;
	logic sh_o, sh_oe;
	localparam int SH_IDX = PINS_PER_CH + FN_FL;

	// Shared pin selection and channel 1 relocation
	always_comb begin
		sh_o = fl_o_f[1];
		sh_oe = fl_oe_f[1];
		cts_next = cts_f;
		if (md1_l) begin
			sh_o = md0_l ? uart_clk_out[1] : ~pol_l[1];
			sh_oe = 1'b1;
			cts_next[1] = 1'b0;
		end else if (sep_l) begin
			sh_o = out_l[SH_IDX];
			sh_oe = dir_l[SH_IDX];
			cts_next[1] = 1'b0;
			cts_next[0] = dir_l[SH_IDX] | fl_src[1];
		end
		tx_o_next = tx_o_f;
		tx_oe_next = tx_oe_f;
		ck_o_next = ck_o_f;
		ck_oe_next = ck_oe_f;
		fl_o_next = fl_o_f;
		fl_oe_next = fl_oe_f;
		fl_o_next[1] = sh_o;
		fl_oe_next[1] = sh_oe;
		for (int c = 0; c < NUM_CH; c++) begin
			rx_o_next[c] = out_l[c*PINS_PER_CH+FN_RX];
			rx_oe_next[c] = dir_l[c*PINS_PER_CH+FN_RX];
		end
		alt_o_next = '0;
		alt_oe_next = '0;
		if (reloc_l) begin
			alt_o_next = {sh_o, ck_o_f[1], rx_o_next[1], tx_o_f[1]};
			alt_oe_next = {sh_oe, ck_oe_f[1], rx_oe_next[1], tx_oe_f[1]};
			tx_o_next[1] = out_l[PINS_PER_CH+FN_TX];
			tx_oe_next[1] = dir_l[PINS_PER_CH+FN_TX];
			rx_oe_next[1] = 1'b0;
			ck_o_next[1] = out_l[PINS_PER_CH+FN_CK];
			ck_oe_next[1] = dir_l[PINS_PER_CH+FN_CK];
			fl_o_next[1] = out_l[SH_IDX];
			fl_oe_next[1] = dir_l[SH_IDX];
		end
		rxd_next = rx_src;
		clk_in_next = ck_in_f;
	end

	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			started_reg <= '0;
			serial_data_out_o <= '0;
			serial_data_out_oe <= '0;
			serial_data_in_o <= '0;
			serial_data_in_oe <= '0;
			transfer_clock_pin_o <= '0;
			transfer_clock_pin_oe <= '0;
			flow_control_pin_o <= '0;
			flow_control_pin_oe <= '0;
			relocated_pin_o <= '0;
			relocated_pin_oe <= '0;
			uart_rxd <= '1;
			uart_clk_in <= '0;
			uart_cts_n <= '1;
		end else begin
			started_reg <= started_next;
			serial_data_out_o <= tx_o_next;
			serial_data_out_oe <= tx_oe_next;
			serial_data_in_o <= rx_o_next;
			serial_data_in_oe <= rx_oe_next;
			transfer_clock_pin_o <= ck_o_next;
			transfer_clock_pin_oe <= ck_oe_next;
			flow_control_pin_o <= fl_o_next;
			flow_control_pin_oe <= fl_oe_next;
			relocated_pin_o <= alt_o_next;
			relocated_pin_oe <= alt_oe_next;
			uart_rxd <= rxd_next;
			uart_clk_in <= clk_in_next;
			uart_cts_n <= cts_next;
		end
	end

	default clocking cb_link @(posedge link_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_idle0;
		en_l[0] && !started_reg[0];
	endsequence
	sequence s_rts2;
		en_l[2] && !fdis_l[2] && fsel_l[2];
	endsequence

	a_idle_level: assert property (s_idle0 and !od_l[0] |=> serial_data_out_o[0] && serial_data_out_oe[0]) else $error("data out not high before first transfer");
	a_idle_float: assert property (s_idle0 and od_l[0] |=> !serial_data_out_oe[0]) else $error("open-drain data out driven while idle");
	a_filler_drive: assert property (en_l[0] && started_reg[0] && !od_l[0] |=>
		serial_data_out_oe[0] && serial_data_out_o[0] == $past(uart_txd[0]))
		else $error("data out not following engine after start");
	a_clock_dir: assert property (en_l[0] |=> transfer_clock_pin_oe[0] == $past(!clock_direction_bit_l[0] || dir_l[FN_CK])) else $error("clock pin direction wrong");
	a_rts_out: assert property (s_rts2 |=> flow_control_pin_oe[2] && flow_control_pin_o[2] == $past(uart_rts_n[2])) else $error("RTS not driven on flow pin");
	a_cts_in: assert property (en_l[2] && !fdis_l[2] && !fsel_l[2] && !dir_l[2*PINS_PER_CH+FN_FL]
		|=> !flow_control_pin_oe[2] && uart_cts_n[2] == $past(fl_s[2]))
		else $error("CTS not taken from flow pin");
	a_extra_static: assert property (md1_l && !md0_l && !reloc_l |=>
		flow_control_pin_oe[1] && flow_control_pin_o[1] == !$past(pol_l[1]))
		else $error("extra clock static level wrong");
	a_sep_cts: assert property (sep_l && !md1_l && !reloc_l && !dir_l[SH_IDX] |=>
		uart_cts_n[0] == $past(fl_s[1]) && !uart_cts_n[1] && !flow_control_pin_oe[1])
		else $error("separated CTS routing wrong");
	a_reloc_move: assert property (reloc_l && en_l[1] && !od_l[1] |=> relocated_pin_oe[FN_TX]
		&& serial_data_out_oe[1] == $past(dir_l[PINS_PER_CH+FN_TX]))
		else $error("channel 1 not relocated");
endmodule

//--- tb/serial_peer_model.sv
// Serial peer model that resolves one group of shared pins against the device
`timescale 1ns/10ps
module serial_peer_model #(
	parameter int W = 1
) (
	input wire logic link_clk, // Pin-side clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic [W-1:0] dut_o, // Device pin level
	input wire logic [W-1:0] dut_oe, // Device pin enable
	input wire logic [W-1:0] peer_val, // Level the peer puts on each line
	input wire logic [W-1:0] peer_en, // Peer drives the line
	output logic [W-1:0] pin_lvl // Resolved wire level
);
	logic [W-1:0] last_reg;
	logic [W-1:0] last_next;
	// An undriven line toggles every cycle so a missing drive cannot pass unseen
	always_comb begin
		for (int b = 0; b < W; b++) begin
			if (dut_oe[b]) begin
				pin_lvl[b] = dut_o[b];
			end else if (peer_en[b]) begin
				pin_lvl[b] = peer_val[b]; // Flow lines low mean ready to accept
			end else begin
				pin_lvl[b] = ~last_reg[b];
			end
		end
		last_next = pin_lvl;
	end
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			last_reg <= '1;
		end else begin
			last_reg <= last_next;
		end
	end
endmodule

//--- tb/uart_pin_flow_control_mux_tb.sv
// Testbench for the serial pin multiplexer with its serial peer
`timescale 1ns/10ps
module uart_pin_flow_control_mux_tb
	import pin_mux_pkg::*;
;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er;
	logic [NUM_CH-1:0] uart_txd = '0, uart_xfer_start = '0, uart_clk_out = '0, uart_rts_n = '1;
	logic [NUM_CH-1:0] uart_rxd, uart_clk_in, uart_cts_n, sd_o, sd_oe, ri_i, ri_o, ri_oe;
	logic [NUM_CH-1:0] ck_i, ck_o, ck_oe, fl_i, fl_o, fl_oe;
	logic [NUM_CH-1:0] p_rx = '1, p_ck = '0, p_cken = '0, p_fl = '1;
	logic [PINS_PER_CH-1:0] rl_i, rl_o, rl_oe;
	logic [PINS_PER_CH-1:0] p_rl = 4'hf;
	int num_errors = 0;
	int n_tests = 0;
	always #2.5 core_clk = ~core_clk;
	always #6 link_clk = ~link_clk;
	uart_pin_flow_control_mux i_uart_pin_flow_control_mux (.core_clk(core_clk),
		.reset_n(reset_n), .link_clk(link_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .uart_txd(uart_txd), .uart_xfer_start(uart_xfer_start),
		.uart_clk_out(uart_clk_out), .uart_rts_n(uart_rts_n), .uart_rxd(uart_rxd),
		.uart_clk_in(uart_clk_in), .uart_cts_n(uart_cts_n), .serial_data_out_o(sd_o),
		.serial_data_out_oe(sd_oe), .serial_data_in_i(ri_i), .serial_data_in_o(ri_o),
		.serial_data_in_oe(ri_oe), .transfer_clock_pin_i(ck_i), .transfer_clock_pin_o(ck_o),
		.transfer_clock_pin_oe(ck_oe), .flow_control_pin_i(fl_i), .flow_control_pin_o(fl_o),
		.flow_control_pin_oe(fl_oe), .relocated_pin_i(rl_i), .relocated_pin_o(rl_o),
		.relocated_pin_oe(rl_oe));
	serial_peer_model #(.W(NUM_CH)) i_serial_peer_model_rx (.link_clk(link_clk),
		.reset_n(reset_n), .dut_o(ri_o), .dut_oe(ri_oe), .peer_val(p_rx), .peer_en(3'h7),
		.pin_lvl(ri_i));
	serial_peer_model #(.W(NUM_CH)) i_serial_peer_model_ck (.link_clk(link_clk),
		.reset_n(reset_n), .dut_o(ck_o), .dut_oe(ck_oe), .peer_val(p_ck), .peer_en(p_cken),
		.pin_lvl(ck_i));
	serial_peer_model #(.W(NUM_CH)) i_serial_peer_model_fl (.link_clk(link_clk),
		.reset_n(reset_n), .dut_o(fl_o), .dut_oe(fl_oe), .peer_val(p_fl), .peer_en(3'h7),
		.pin_lvl(fl_i));
	serial_peer_model #(.W(PINS_PER_CH)) i_serial_peer_model_rl (.link_clk(link_clk),
		.reset_n(reset_n), .dut_o(rl_o), .dut_oe(rl_oe), .peer_val(p_rl), .peer_en(4'h2),
		.pin_lvl(rl_i));
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			num_errors++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk(er, e);
	endtask
	// Config crosses in three link edges; six leave margin for the pin synchronisers
	task automatic settle();
		repeat (6) @(posedge link_clk);
		@(negedge link_clk);
	endtask
	initial begin
		#400000;
		num_errors++;
		final_report();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int c = 0; c < NUM_CH; c++) begin
			rdchk(MODE_OFS[c], 32'h0, 1'b0);
			rdchk(CTRL_OFS[c], 32'h2, 1'b0);
		end
		rdchk(SHARED_OFS, 32'h0, 1'b0);
		rdchk(8'h3c, 32'h0, 1'b1);
		settle();
		chk(uart_cts_n, 3'h0);
		chk(sd_oe, 3'h0);
		apb(1'b1, MODE_OFS[0], 32'h1);
		apb(1'b1, MODE_OFS[2], 32'h5);
		@(posedge link_clk);
		p_rx <= 3'h6;
		settle();
		chk({sd_o[0], sd_oe[0]}, 2'b11);
		chk(sd_oe[2], 1'b0);
		chk(uart_rxd[0], 1'b0);
		@(posedge link_clk);
		uart_xfer_start <= 3'h5;
		settle();
		chk({sd_o[0], sd_oe[0]}, 2'b01);
		chk({sd_o[2], sd_oe[2]}, 2'b01);
		@(posedge link_clk);
		uart_txd <= 3'h5;
		uart_clk_out <= 3'h1;
		settle();
		chk({sd_o[0], sd_oe[0], sd_oe[2]}, 3'b110);
		chk({ck_o[0], ck_oe[0]}, 2'b11);
		apb(1'b1, MODE_OFS[0], 32'h3);
		@(posedge link_clk);
		p_cken <= 3'h1;
		p_ck <= 3'h1;
		settle();
		chk({ck_oe[0], uart_clk_in[0]}, 2'b01);
		apb(1'b1, PORT6_DIR_OFS, 32'h6);
		settle();
		chk(uart_clk_in[0], 1'b0);
		chk({ri_o[0], ri_oe[0], ck_oe[0]}, 3'b011);
		apb(1'b1, PORT6_DIR_OFS, 32'h0);
		apb(1'b1, PORT7_DIR_OFS, 32'h8);
		apb(1'b1, PORT_DATA_OFS, 32'h800);
		settle();
		chk({fl_o[2], fl_oe[2]}, 2'b11);
		apb(1'b1, CTRL_OFS[2], 32'h0);
		apb(1'b1, PORT7_DIR_OFS, 32'h0);
		@(posedge link_clk);
		p_fl <= 3'h3;
		settle();
		chk({fl_oe[2], uart_cts_n[2]}, 2'b00);
		apb(1'b1, PORT7_DIR_OFS, 32'h8);
		settle();
		chk(uart_cts_n[2], 1'b1);
		apb(1'b1, CTRL_OFS[2], 32'h1);
		@(posedge link_clk);
		uart_rts_n <= 3'h3;
		settle();
		chk({fl_o[2], fl_oe[2]}, 2'b01);
		apb(1'b1, MODE_OFS[1], 32'h1);
		apb(1'b1, CTRL_OFS[1], 32'h0);
		settle();
		chk(uart_cts_n[1], 1'b1);
		@(posedge link_clk);
		p_fl <= 3'h1;
		settle();
		chk(uart_cts_n[1], 1'b0);
		apb(1'b1, CTRL_OFS[0], 32'h1);
		apb(1'b1, SHARED_OFS, 32'h1);
		@(posedge link_clk);
		uart_rts_n <= 3'h2;
		settle();
		chk({fl_o[0], fl_oe[0]}, 2'b01);
		chk({uart_cts_n[0], fl_oe[1]}, 2'b00);
		@(posedge link_clk);
		p_fl <= 3'h3;
		settle();
		chk(uart_cts_n[1:0], 2'b01);
		apb(1'b1, SHARED_OFS, 32'h4);
		settle();
		chk({fl_o[1], fl_oe[1]}, 2'b11);
		apb(1'b1, SHARED_OFS, 32'h6);
		settle();
		chk({fl_o[1], fl_oe[1]}, 2'b01);
		apb(1'b1, SHARED_OFS, 32'h4);
		apb(1'b1, CTRL_OFS[1], 32'h4);
		settle();
		chk({fl_o[1], fl_oe[1]}, 2'b01);
		apb(1'b1, PIN_ASSIGN_OFS, 32'h1);
		apb(1'b1, MODE_OFS[1], 32'h1);
		@(posedge link_clk);
		p_rl <= 4'hd;
		settle();
		chk({rl_o[0], rl_oe[0], rl_o[3], rl_oe[3]}, 4'b1101);
		chk({sd_oe[1], fl_oe[1]}, 2'b00);
		chk(uart_rxd[1], 1'b0);
		final_report();
	end
endmodule
